/* core/sdc_pkg.sv */
// constants and types for the control and address input decoder
package sdc_pkg;
	// pin and bus widths
	localparam int ADDR_W = 14; // row, column and opcode pins
	localparam int BA_W = 2; // bank address pins
	localparam int DQ_W = 8; // data pins
	localparam int LANES = 1; // byte lanes, one mask each
	localparam int COL_W = 10; // column bits below the flag bit
	// field positions on the address pins
	localparam int AP_BIT = 10; // auto precharge / all banks
	localparam int EMR_RTT_LO = 2; // termination value, low bit
	localparam int EMR_RTT_HI = 6; // termination value, high bit
	localparam int EMR_RDQS = 11; // mask pin becomes read strobe
	// bank codes that pick a mode register
	localparam logic [1:0] BA_MR = 2'h0; // main mode register
	localparam logic [1:0] BA_EMR1 = 2'h1; // first extended register
	// data beats in one burst, one beat per clock here
	localparam logic [2:0] BURST_BEATS = 3'h4;
	localparam logic [2:0] BURST_NONE = 3'h0;
	localparam logic [2:0] BURST_LAST = 3'h1;
	// power states, gray coded along power-down entry and exit; self refresh entry and exit flip both bits
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'h0,
		PWR_PRE_PD = 2'h1,
		PWR_SELF = 2'h3,
		PWR_ACT_PD = 2'h2
	} sdc_pwr_t;
	// decoded commands
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_WR = 3'h3,
		CMD_PRE = 3'h4,
		CMD_REF = 3'h5,
		CMD_MRS = 3'h6,
		CMD_DESEL = 3'h7
	} sdc_cmd_t;
endpackage

/* core/sdc_decode.sv */
// control and address input decoder of the memory device
// How it works
// [R1] all inputs captured on the clock rise
// [R2] low clock enable stops buffers and drivers
// [R3] idle banks pick precharge or self refresh
// [R4] self refresh exit seen through a synchroniser
// [R5] controller keeps clock enable high in bursts
// [R6] power-down keeps only clock, termination, enable
// [R7] self refresh keeps only the enable buffer
// [R8] high chip select masks the command
// [R9] command from select and three strobes together
// [R10] termination on data, strobes and masks
// [R11] termination off in mode register ignores pin
// [R12] high mask discards that write beat
// [R13] x8 mask pin may become read strobe
// [R14] bank pins pick bank or mode register
// [R15] precharge closes one bank or all
// [R16] row on activate, column on read/write
// [R17] mode set takes address pins as opcode
// [R18] device drives data only while reading
`timescale 1ns/1ps
module sdc_decode #(
	parameter int ADDR_W = sdc_pkg::ADDR_W,
	parameter int BA_W = sdc_pkg::BA_W,
	parameter int DQ_W = sdc_pkg::DQ_W,
	parameter int LANES = sdc_pkg::LANES,
	parameter int COL_W = sdc_pkg::COL_W,
	parameter bit IS_X8 = 1'b1
) (
	input logic CLK,
	input logic RST_B,
	input logic CLK_EN,
	input logic CKE,
	input logic CS_B,
	input logic RAS_B,
	input logic CAS_B,
	input logic WE_B,
	input logic ODT,
	input logic [BA_W-1:0] BA,
	input logic [ADDR_W-1:0] ADDR,
	input logic [LANES-1:0] DM,
	input logic [DQ_W-1:0] DQ_IN,
	input logic [DQ_W-1:0] RD_DATA,
	output logic [DQ_W-1:0] DQ_OUT,
	output logic DQ_OE,
	output logic CMD_VALID,
	output sdc_pkg::sdc_cmd_t CMD_CODE,
	output logic [BA_W-1:0] CMD_BANK,
	output logic [ADDR_W-1:0] CMD_ROW,
	output logic [COL_W-1:0] CMD_COL,
	output logic [ADDR_W-1:0] CMD_OPCODE,
	output logic CMD_AUTO_PRE,
	output logic CMD_ALL_BANKS,
	output logic [(1<<BA_W)-1:0] BANK_OPEN,
	output logic [DQ_W-1:0] WR_DATA,
	output logic WR_BEAT,
	output logic [LANES-1:0] WR_LANE_EN,
	output sdc_pkg::sdc_pwr_t PWR_STATE,
	output logic CLK_BUF_ON,
	output logic CMD_BUF_ON,
	output logic ODT_BUF_ON,
	output logic DRV_ON,
	output logic TERM_ON,
	output logic DM_AS_RDQS
);
	localparam int BANKS = 1 << BA_W;

	// parameters the logic cannot serve
	if (COL_W > sdc_pkg::AP_BIT || ADDR_W <= sdc_pkg::EMR_RDQS ||
		BA_W < 2 || LANES < 1 || DQ_W % LANES != 0) begin : g_bad
		$error("sdc_decode: unsupported parameters");
	end

	// command from select and the three strobes
	function automatic sdc_pkg::sdc_cmd_t decode(input logic [3:0] p);
		case (p)
			4'h3: decode = sdc_pkg::CMD_ACT;
			4'h5: decode = sdc_pkg::CMD_RD;
			4'h4: decode = sdc_pkg::CMD_WR;
			4'h2: decode = sdc_pkg::CMD_PRE;
			4'h1: decode = sdc_pkg::CMD_REF;
			4'h0: decode = sdc_pkg::CMD_MRS;
			4'h7: decode = sdc_pkg::CMD_NOP;
			default: decode = sdc_pkg::CMD_DESEL;
		endcase
	endfunction

	// captured pins
	logic r_cke, r_cs_b, r_ras_b, r_cas_b, r_we_b, r_odt;
	logic next_cke, next_cs_b, next_ras_b, next_cas_b, next_we_b;
	logic next_odt;
	logic [BA_W-1:0] r_ba, next_ba;
	logic [ADDR_W-1:0] r_addr, next_addr;
	logic [LANES-1:0] r_dm, next_dm;
	logic [DQ_W-1:0] r_dq, next_dq;
	logic cke_s1, cke_s2, next_cke_s1, next_cke_s2; // exit synchroniser

	// input capture, gated by which buffers are powered
	always_comb begin
		next_cke = CKE; // [R1]
		next_cke_s1 = CKE;
		next_cke_s2 = cke_s1;
		next_odt = ODT_BUF_ON ? ODT : r_odt; // [R6] [R7]
		next_dq = DQ_IN;
		next_dm = DM;
		if (CMD_BUF_ON) begin // [R6] [R7]
			next_cs_b = CS_B; // [R1]
			next_ras_b = RAS_B;
			next_cas_b = CAS_B;
			next_we_b = WE_B;
			next_ba = BA;
			next_addr = ADDR;
		end else begin
			next_cs_b = 1'b1; // buffers off read as deselect
			next_ras_b = r_ras_b;
			next_cas_b = r_cas_b;
			next_we_b = r_we_b;
			next_ba = r_ba;
			next_addr = r_addr;
		end
	end

	// input registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			r_cke <= 1'b1; // awake after reset, no false power-down
			cke_s1 <= 1'b0;
			cke_s2 <= 1'b0;
			r_cs_b <= 1'b1;
			r_ras_b <= 1'b1;
			r_cas_b <= 1'b1;
			r_we_b <= 1'b1;
			r_odt <= 1'b0;
			r_ba <= '0;
			r_addr <= '0;
			r_dm <= '0;
			r_dq <= '0;
		end else if (CLK_EN) begin
			r_cke <= next_cke;
			cke_s1 <= next_cke_s1;
			cke_s2 <= next_cke_s2;
			r_cs_b <= next_cs_b;
			r_ras_b <= next_ras_b;
			r_cas_b <= next_cas_b;
			r_we_b <= next_we_b;
			r_odt <= next_odt;
			r_ba <= next_ba;
			r_addr <= next_addr;
			r_dm <= next_dm;
			r_dq <= next_dq;
		end
	end

	// decoded command of the captured cycle
	sdc_pkg::sdc_cmd_t cmd;
	logic exec; // device awake and enabled
	assign cmd = decode({r_cs_b, r_ras_b, r_cas_b, r_we_b}); // [R8] [R9]
	assign exec = (PWR_STATE == sdc_pkg::PWR_ACTIVE) && r_cke;

	// power state and buffer enables
	sdc_pkg::sdc_pwr_t next_pwr;
	logic next_clk_buf, next_cmd_buf, next_odt_buf, next_drv;
	always_comb begin
		next_pwr = PWR_STATE;
		case (PWR_STATE)
			sdc_pkg::PWR_ACTIVE: begin
				if (!r_cke) begin // [R4]
					if (cmd == sdc_pkg::CMD_REF) begin
						next_pwr = sdc_pkg::PWR_SELF; // [R3]
					end else if (|BANK_OPEN) begin
						next_pwr = sdc_pkg::PWR_ACT_PD; // [R3]
					end else begin
						next_pwr = sdc_pkg::PWR_PRE_PD; // [R3]
					end
				end
			end
			sdc_pkg::PWR_PRE_PD, sdc_pkg::PWR_ACT_PD: begin
				if (r_cke) begin // clocked exit [R4]
					next_pwr = sdc_pkg::PWR_ACTIVE;
				end
			end
			sdc_pkg::PWR_SELF: begin
				if (cke_s2) begin // asynchronous exit [R4]
					next_pwr = sdc_pkg::PWR_ACTIVE;
				end
			end
			default: next_pwr = sdc_pkg::PWR_ACTIVE;
		endcase
		next_cmd_buf = next_pwr == sdc_pkg::PWR_ACTIVE; // [R6]
		next_drv = next_cmd_buf && next_cke; // [R2]
		next_clk_buf = next_pwr != sdc_pkg::PWR_SELF; // [R7]
		next_odt_buf = next_clk_buf; // [R6] [R7]
	end

	// power registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			PWR_STATE <= sdc_pkg::PWR_ACTIVE;
			CLK_BUF_ON <= 1'b1;
			CMD_BUF_ON <= 1'b1;
			ODT_BUF_ON <= 1'b1;
			DRV_ON <= 1'b0;
		end else if (CLK_EN) begin
			PWR_STATE <= next_pwr;
			CLK_BUF_ON <= next_clk_buf;
			CMD_BUF_ON <= next_cmd_buf;
			ODT_BUF_ON <= next_odt_buf;
			DRV_ON <= next_drv;
		end
	end

	// command, bank and burst state
	logic rtt_en, next_rtt_en; // termination enabled in mode register
	logic [2:0] burst_left, next_burst_left;
	logic burst_wr, next_burst_wr;
	logic burst_ap, next_burst_ap;
	logic [BA_W-1:0] burst_bank, next_burst_bank;
	logic next_valid, next_ap, next_all, next_beat, next_oe, next_rdqs;
	logic next_term;
	sdc_pkg::sdc_cmd_t next_code;
	logic [BA_W-1:0] next_bank;
	logic [ADDR_W-1:0] next_row, next_op;
	logic [COL_W-1:0] next_col;
	logic [BANKS-1:0] next_open;
	logic [DQ_W-1:0] next_wdata, next_dout;
	logic [LANES-1:0] next_lane;
	always_comb begin
		next_valid = 1'b0;
		next_code = CMD_CODE;
		next_bank = CMD_BANK;
		next_row = CMD_ROW;
		next_col = CMD_COL;
		next_op = CMD_OPCODE;
		next_ap = CMD_AUTO_PRE;
		next_all = CMD_ALL_BANKS;
		next_open = BANK_OPEN;
		next_rtt_en = rtt_en;
		next_rdqs = DM_AS_RDQS;
		next_burst_left = burst_left;
		next_burst_wr = burst_wr;
		next_burst_ap = burst_ap;
		next_burst_bank = burst_bank;
		next_beat = 1'b0;
		next_wdata = WR_DATA;
		next_lane = WR_LANE_EN;
		next_oe = 1'b0;
		next_dout = DQ_OUT;
		// burst beats in progress
		if (burst_left != sdc_pkg::BURST_NONE) begin
			next_burst_left = burst_left - sdc_pkg::BURST_LAST;
			if (burst_wr) begin
				next_beat = 1'b1;
				next_wdata = r_dq;
				// masking is off while the pin is a strobe [R13]
				next_lane = DM_AS_RDQS ? '1 : ~r_dm; // [R12]
			end else begin
				next_oe = DRV_ON && r_cke; // [R2] [R18]
				next_dout = RD_DATA;
			end
			if (burst_left == sdc_pkg::BURST_LAST && burst_ap) begin
				next_open[burst_bank] = 1'b0;
			end
		end
		// new command, masked by chip select [R8]
		if (exec && cmd != sdc_pkg::CMD_DESEL &&
			cmd != sdc_pkg::CMD_NOP) begin
			next_valid = 1'b1; // [R9]
			next_code = cmd;
			next_bank = r_ba; // [R14]
			case (cmd)
				sdc_pkg::CMD_ACT: begin
					next_row = r_addr; // [R16]
					next_open[r_ba] = 1'b1;
				end
				sdc_pkg::CMD_RD, sdc_pkg::CMD_WR: begin
					next_col = r_addr[COL_W-1:0]; // [R16]
					next_ap = r_addr[sdc_pkg::AP_BIT];
					next_burst_left = sdc_pkg::BURST_BEATS;
					next_burst_wr = cmd == sdc_pkg::CMD_WR;
					next_burst_ap = r_addr[sdc_pkg::AP_BIT];
					next_burst_bank = r_ba;
				end
				sdc_pkg::CMD_PRE: begin
					next_all = r_addr[sdc_pkg::AP_BIT]; // [R15]
					if (next_all) begin
						next_open = '0; // [R15]
					end else begin
						next_open[r_ba] = 1'b0; // [R15]
					end
				end
				sdc_pkg::CMD_MRS: begin
					next_op = r_addr; // [R17]
					if (r_ba[1:0] == sdc_pkg::BA_EMR1) begin // [R14]
						next_rtt_en = r_addr[sdc_pkg::EMR_RTT_LO] |
							r_addr[sdc_pkg::EMR_RTT_HI];
						next_rdqs = IS_X8 &&
							r_addr[sdc_pkg::EMR_RDQS]; // [R13]
					end
				end
				default: begin
					next_valid = 1'b1; // refresh passes through
				end
			endcase
		end
		// pin honoured only with termination enabled [R10] [R11]
		next_term = r_odt && next_rtt_en && ODT_BUF_ON;
	end

	// command and data registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CMD_VALID <= 1'b0;
			CMD_CODE <= sdc_pkg::CMD_NOP;
			CMD_BANK <= '0;
			CMD_ROW <= '0;
			CMD_COL <= '0;
			CMD_OPCODE <= '0;
			CMD_AUTO_PRE <= 1'b0;
			CMD_ALL_BANKS <= 1'b0;
			BANK_OPEN <= '0;
			rtt_en <= 1'b0;
			DM_AS_RDQS <= 1'b0;
			TERM_ON <= 1'b0;
			burst_left <= sdc_pkg::BURST_NONE;
			burst_wr <= 1'b0;
			burst_ap <= 1'b0;
			burst_bank <= '0;
			WR_BEAT <= 1'b0;
			WR_DATA <= '0;
			WR_LANE_EN <= '0;
			DQ_OE <= 1'b0;
			DQ_OUT <= '0;
		end else if (CLK_EN) begin
			CMD_VALID <= next_valid;
			CMD_CODE <= next_code;
			CMD_BANK <= next_bank;
			CMD_ROW <= next_row;
			CMD_COL <= next_col;
			CMD_OPCODE <= next_op;
			CMD_AUTO_PRE <= next_ap;
			CMD_ALL_BANKS <= next_all;
			BANK_OPEN <= next_open;
			rtt_en <= next_rtt_en;
			DM_AS_RDQS <= next_rdqs;
			TERM_ON <= next_term;
			burst_left <= next_burst_left;
			burst_wr <= next_burst_wr;
			burst_ap <= next_burst_ap;
			burst_bank <= next_burst_bank;
			WR_BEAT <= next_beat;
			WR_DATA <= next_wdata;
			WR_LANE_EN <= next_lane;
			DQ_OE <= next_oe;
			DQ_OUT <= next_dout;
		end
	end

	// checks on the decoder
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B || !CLK_EN);
	sequence sr_go;
		exec == 1'b0 && PWR_STATE == sdc_pkg::PWR_ACTIVE && !r_cke &&
			cmd == sdc_pkg::CMD_REF;
	endsequence
	sequence sr_held;
		PWR_STATE == sdc_pkg::PWR_SELF && !CLK_BUF_ON && !CMD_BUF_ON;
	endsequence
	sr_entry_a: assert property (sr_go |=> sr_held) // [R7]
		else $error("self refresh entry missed");
	pd_entry_a: assert property (PWR_STATE == sdc_pkg::PWR_ACTIVE &&
		!r_cke && cmd != sdc_pkg::CMD_REF && |BANK_OPEN
		|=> PWR_STATE == sdc_pkg::PWR_ACT_PD && ODT_BUF_ON) // [R3]
		else $error("active power-down entry wrong");
	cs_mask_a: assert property (r_cs_b |=> !CMD_VALID) // [R8]
		else $error("deselected command executed");
	cmd_code_a: assert property (exec && cmd == sdc_pkg::CMD_RD
		|=> CMD_VALID && CMD_CODE == sdc_pkg::CMD_RD) // [R9]
		else $error("read not decoded");
	pre_all_a: assert property (exec && cmd == sdc_pkg::CMD_PRE &&
		r_addr[sdc_pkg::AP_BIT] |=> BANK_OPEN == '0) // [R15]
		else $error("precharge all left a bank open");
	act_row_a: assert property (exec && cmd == sdc_pkg::CMD_ACT
		|=> CMD_ROW == $past(r_addr) && BANK_OPEN[CMD_BANK]) // [R16]
		else $error("activate row or bank wrong");
	odt_ign_a: assert property (TERM_ON |-> rtt_en) // [R11]
		else $error("termination on while disabled");
	wr_mask_a: assert property (WR_BEAT && !$past(DM_AS_RDQS)
		|-> WR_LANE_EN == ~$past(r_dm)) // [R12]
		else $error("write mask not applied");
	drv_off_a: assert property (!r_cke |=> !DQ_OE) // [R2]
		else $error("driver on with clock enable low");
	wr_beats_a: assert property (exec && cmd == sdc_pkg::CMD_WR
		|=> ##1 WR_BEAT [*4]) // [R12]
		else $error("write burst beat count wrong");
endmodule

/* test/sdc_ctrl_model.sv */
// behavioural memory controller that drives the decoder's pins
`timescale 1ns/1ps
module sdc_ctrl_model (
	input wire logic clk,
	output logic cke,
	output logic cs_b,
	output logic ras_b,
	output logic cas_b,
	output logic we_b,
	output logic odt,
	output logic [1:0] ba,
	output logic [13:0] addr,
	output logic [0:0] dm,
	output logic [7:0] dq_in,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe
);
	logic own_oe; // controller drives the data wire
	logic [7:0] wd; // write beat value
	logic [7:0] last_dq; // last level seen on the data wire
	// resolved data wire; nobody driving gives a changing pattern
	assign dq_in = own_oe ? wd : (dq_oe ? dq_out : ~last_dq);
	// remember the wire so an idle bus never looks stable
	always @(posedge clk) begin
		last_dq <= dq_in;
	end
	// idle pins: clock enabled, deselected
	initial begin
		cke = 1'b1;
		{cs_b, ras_b, cas_b, we_b} = 4'hF;
		odt = 1'b0;
		ba = 2'h0;
		addr = 14'h0;
		dm = 1'h0;
		own_oe = 1'b0;
		wd = 8'h0;
		last_dq = 8'h0;
	end
	// step to just after the sampling crossing
	task automatic tick();
		@(posedge clk);
		#2;
	endtask
	// one command cycle, then deselect with flipped address lines
	task automatic cmd(input logic [3:0] c, input logic [1:0] b,
		input logic [13:0] a);
		{cs_b, ras_b, cas_b, we_b} = c;
		ba = b;
		addr = a;
		tick();
		{cs_b, ras_b, cas_b, we_b} = 4'hF;
		ba = ~b;
		addr = ~a;
	endtask
	// present one write beat with its mask
	task automatic beat(input logic [7:0] d, input logic m);
		own_oe = 1'b1;
		wd = d;
		dm = m;
	endtask
	// let go of the data wire after a write burst
	task automatic idle_dq();
		own_oe = 1'b0;
		dm = ~dm;
	endtask
	// callers only change the enable outside bursts
	task automatic set_cke(input logic v);
		cke = v;
	endtask
	// termination request level
	task automatic set_odt(input logic v);
		odt = v;
	endtask
endmodule

/* test/tb.sv */
// self-checking bench for the control and address input decoder
`timescale 1ns/1ps
module tb;
	localparam logic [3:0] C_ACT = 4'h3; // select and strobe codes
	localparam logic [3:0] C_RD = 4'h5;
	localparam logic [3:0] C_WR = 4'h4;
	localparam logic [3:0] C_PRE = 4'h2;
	localparam logic [3:0] C_REF = 4'h1;
	localparam logic [3:0] C_MRS = 4'h0;
	logic clk, rst_b, clk_en, cke, cs_b, ras_b, cas_b, we_b, odt;
	logic [1:0] ba, cmd_bank, b;
	logic [13:0] addr, cmd_row, cmd_opcode, a;
	logic [0:0] dm, wr_lane_en;
	logic [7:0] dq_in, rd_data, dq_out, wr_data;
	logic dq_oe, cmd_valid, cmd_auto_pre, cmd_all_banks, wr_beat;
	logic clk_buf_on, cmd_buf_on, odt_buf_on, drv_on, term_on, dm_as_rdqs;
	logic [9:0] cmd_col;
	logic [3:0] bank_open, open_exp; // open_exp: expected open rows
	logic rdqs_exp; // mask pin expected to be a read strobe
	sdc_pkg::sdc_cmd_t cmd_code;
	sdc_pkg::sdc_pwr_t pwr_state;
	int error_cnt, n_tests, i;
	sdc_decode u_dut (.CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en),
		.CKE(cke), .CS_B(cs_b), .RAS_B(ras_b), .CAS_B(cas_b), .WE_B(we_b),
		.ODT(odt), .BA(ba), .ADDR(addr), .DM(dm), .DQ_IN(dq_in),
		.RD_DATA(rd_data), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
		.CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_BANK(cmd_bank),
		.CMD_ROW(cmd_row), .CMD_COL(cmd_col), .CMD_OPCODE(cmd_opcode),
		.CMD_AUTO_PRE(cmd_auto_pre), .CMD_ALL_BANKS(cmd_all_banks),
		.BANK_OPEN(bank_open), .WR_DATA(wr_data), .WR_BEAT(wr_beat),
		.WR_LANE_EN(wr_lane_en), .PWR_STATE(pwr_state),
		.CLK_BUF_ON(clk_buf_on), .CMD_BUF_ON(cmd_buf_on),
		.ODT_BUF_ON(odt_buf_on), .DRV_ON(drv_on), .TERM_ON(term_on),
		.DM_AS_RDQS(dm_as_rdqs));
	sdc_ctrl_model u_ctl (.clk(clk), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
		.cas_b(cas_b), .we_b(we_b), .odt(odt), .ba(ba), .addr(addr),
		.dm(dm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// expected lane keep: strobe mode turns masking off
	function automatic logic lane_exp(input logic m, input logic rq);
		return rq | ~m;
	endfunction
	// expected termination from pin and extended register value
	function automatic logic term_exp(input logic o, input logic [13:0] p);
		return o & (p[sdc_pkg::EMR_RTT_LO] | p[sdc_pkg::EMR_RTT_HI]);
	endfunction
	// one comparison, reported at once on mismatch
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#2;
	endtask
	// command cycle plus the edge that answers it
	task automatic do_cmd(input logic [3:0] c, input logic [1:0] bb,
		input logic [13:0] aa);
		u_ctl.cmd(c, bb, aa);
		tick();
	endtask
	// write command with four random masked beats
	task automatic wr_burst(input logic [1:0] bb, input logic [13:0] aa);
		logic [7:0] d[4];
		logic m[4];
		u_ctl.cmd(C_WR, bb, aa);
		for (int k = 0; k < 5; k++) begin
			if (k < 4) begin
				d[k] = 8'($urandom);
				m[k] = 1'($urandom);
				u_ctl.beat(d[k], m[k]);
			end else begin
				u_ctl.idle_dq();
			end
			tick();
			if (k == 0) begin
				chk(16'(cmd_col), 16'(aa[9:0]));
				chk(16'(cmd_auto_pre), 16'(aa[10]));
				chk(16'(wr_beat), 16'h0);
			end else begin
				chk(16'(wr_beat), 16'h1);
				chk(16'(wr_data), 16'(d[k-1]));
				chk(16'(wr_lane_en), 16'(lane_exp(m[k-1], rdqs_exp)));
			end
		end
		if (aa[10]) open_exp[bb] = 1'b0;
		chk(16'(bank_open), 16'(open_exp));
		tick();
		chk(16'(wr_beat), 16'h0);
	endtask
	// power-down entry, then the expected state, then exit
	task automatic pd(input sdc_pkg::sdc_pwr_t st);
		u_ctl.set_cke(1'b0);
		repeat (2) tick();
		chk(16'(pwr_state), 16'(st));
		chk(16'(cmd_buf_on), 16'h0);
		chk(16'(clk_buf_on), 16'h1);
		chk(16'(odt_buf_on), 16'h1);
		chk(16'(drv_on), 16'h0);
		do_cmd(C_ACT, 2'h0, 14'h0);
		chk(16'(cmd_valid), 16'h0);
		u_ctl.set_cke(1'b1);
		repeat (2) tick();
		chk(16'(pwr_state), 16'(sdc_pkg::PWR_ACTIVE));
		chk(16'(cmd_buf_on), 16'h1);
	endtask
	// closing verdict
	task automatic report_and_stop();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#(25 * 4000);
		error_cnt++;
		report_and_stop();
	end
	// main sequence
	initial begin
		void'($urandom(97051));
		{error_cnt, n_tests, open_exp, rdqs_exp} = '0;
		rst_b = 1'b0;
		clk_en = 1'b1;
		rd_data = 8'h0;
		repeat (3) @(posedge clk);
		#2 rst_b = 1'b1;
		tick();
		chk(16'(pwr_state), 16'(sdc_pkg::PWR_ACTIVE));
		chk(16'(drv_on), 16'h1);
		for (i = 0; i < 6; i++) begin
			b = 2'($urandom);
			a = 14'($urandom);
			do_cmd(C_ACT, b, a);
			open_exp[b] = 1'b1;
			chk(16'(cmd_valid), 16'h1);
			chk(16'(cmd_code), 16'(sdc_pkg::CMD_ACT));
			chk(16'(cmd_row), 16'(a));
			chk(16'(cmd_bank), 16'(b));
			chk(16'(bank_open), 16'(open_exp));
		end
		do_cmd(C_REF, 2'h0, 14'h0);
		chk(16'(cmd_valid), 16'h1);
		chk(16'(cmd_code), 16'(sdc_pkg::CMD_REF));
		do_cmd(4'hB, 2'h1, 14'h0);
		chk(16'(cmd_valid), 16'h0);
		a = 14'($urandom) & 14'h3BFF;
		do_cmd(C_PRE, b, a);
		open_exp[b] = 1'b0;
		chk(16'(cmd_all_banks), 16'h0);
		chk(16'(bank_open), 16'(open_exp));
		wr_burst(2'($urandom), 14'($urandom) & 14'h3BFF);
		do_cmd(C_ACT, 2'h2, 14'h0);
		open_exp[2] = 1'b1;
		wr_burst(2'h2, 14'h0400 | 14'($urandom));
		u_ctl.cmd(C_RD, 2'h1, 14'h0);
		tick();
		chk(16'(dq_oe), 16'h0);
		for (i = 0; i < 4; i++) begin
			rd_data = 8'($urandom);
			a[7:0] = rd_data;
			tick();
			chk(16'(dq_oe), 16'h1);
			chk(16'(dq_out), 16'(a[7:0]));
		end
		tick();
		chk(16'(dq_oe), 16'h0);
		u_ctl.set_odt(1'b1);
		a = 14'($urandom) | 14'h0804;
		do_cmd(C_MRS, sdc_pkg::BA_EMR1, a);
		chk(16'(cmd_opcode), 16'(a));
		chk(16'(cmd_bank), 16'(sdc_pkg::BA_EMR1));
		tick();
		rdqs_exp = 1'b1;
		chk(16'(dm_as_rdqs), 16'h1);
		chk(16'(term_on), 16'(term_exp(1'b1, a)));
		u_ctl.set_odt(1'b0);
		repeat (2) tick();
		chk(16'(term_on), 16'h0);
		u_ctl.set_odt(1'b1);
		wr_burst(2'h0, 14'($urandom) & 14'h3BFF);
		a = 14'($urandom) & 14'h37BB;
		do_cmd(C_MRS, sdc_pkg::BA_EMR1, a);
		tick();
		rdqs_exp = 1'b0;
		chk(16'(term_on), 16'(term_exp(1'b1, a)));
		chk(16'(dm_as_rdqs), 16'h0);
		do_cmd(C_ACT, 2'h3, 14'h0); // keep a row open
		open_exp[3] = 1'b1;
		chk(16'(bank_open), 16'(open_exp));
		pd(sdc_pkg::PWR_ACT_PD);
		do_cmd(C_PRE, 2'h0, 14'h0400);
		open_exp = 4'h0;
		chk(16'(cmd_all_banks), 16'h1);
		chk(16'(bank_open), 16'h0);
		pd(sdc_pkg::PWR_PRE_PD);
		u_ctl.set_cke(1'b0);
		do_cmd(C_REF, 2'h0, 14'h0);
		chk(16'(pwr_state), 16'(sdc_pkg::PWR_SELF));
		chk(16'(clk_buf_on), 16'h0);
		chk(16'(odt_buf_on), 16'h0);
		chk(16'(drv_on), 16'h0);
		u_ctl.set_cke(1'b1);
		repeat (2) tick();
		chk(16'(pwr_state), 16'(sdc_pkg::PWR_SELF));
		tick();
		chk(16'(pwr_state), 16'(sdc_pkg::PWR_ACTIVE));
		chk(16'(clk_buf_on), 16'h1);
		report_and_stop();
	end
endmodule
